//--- hdl/sca_host_port.sv
`timescale 1ns/1ps
// Function
// - first cs-and-read low interval clears the completion interrupt.
// - a cs-and-write low interval also clears the completion interrupt.
// - ready output stretches host read or write by wait states.
// - calibrate and convert are separate commands, any order, no recal needed.
// - calibrate runs 105 clocks, conversion runs 27 clocks.
// - command captured from top six data lines when cs or write rises.
// - convert is D15 high D14 low D10 low; calibrate D15,D13..D10 low.
// - stopped converter clock invalidates calibration.
// - result saturates at 0111111111111 and 1000000000000.
// - magnitude zero at zero input, full scale at reference.
// - convert during a conversion restarts from its first cycle.
// - end of cycle 27 asserts interrupt low; new conversion allowed at once.
// - cs and read low drive all 13 result bits, sign extended.
// - analog input is sampled during conversion cycles 3 through 10.
module sca_host_port
    import sca_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host bus
    input sca_strobe_t strobe,
    input wire logic [15:0] dataIn,
    output logic [15:0] dataOut,
    output logic dataOe,
    output logic readyOut,
    output logic intN,
    // converter clock health and strap
    input wire logic convClkRun,
    input wire logic strapInput,
    // analog front end, digitised
    input wire logic inNegative,
    input wire logic [12:0] inMagnitude,
    input wire logic [12:0] refMagnitude,
    // status
    output logic samplingOut,
    output logic calValidOut,
    output logic busyOut
);
    sca_state_t state_reg, state_next;
    logic [6:0] cnt_reg, cnt_next;
    logic intN_reg, intN_next;
    logic calValid_reg;
    logic rdLow_reg, wrLow_reg;
    logic readDone_reg;
    logic [12:0] res_reg;
    logic [1:0] wait_reg;
    logic [15:0] cmdLatch_reg;
    sca_cmd_t cmd;

    // combined low intervals and their edges
    wire rdLow = ~strobe.csN & ~strobe.rdN;
    wire wrLow = ~strobe.csN & ~strobe.wrN;
    wire rdFall = rdLow & ~rdLow_reg;
    wire wrFall = wrLow & ~wrLow_reg;
    wire wrRise = ~wrLow & wrLow_reg;
    wire strapOk = strapInput;

    // decode the latched command word at the rising end
    sca_cmd_decode u_dec (
        .field(cmdLatch_reg[CMD_MSB:CMD_LSB]),
        .cmd(cmd)
    );
    wire startConv = wrRise & strapOk & (cmd == SCA_CMD_CONV);
    wire startCal = wrRise & strapOk & (cmd == SCA_CMD_CAL);

    wire convDone = (state_reg == SCA_CONV) && (cnt_reg == CONV_CYCLES);
    wire calDone = (state_reg == SCA_CAL) && (cnt_reg == CAL_CYCLES);

    // sequence control
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        if (startConv) begin
            state_next = SCA_CONV;
            cnt_next = 7'h01;
        end else if (startCal) begin
            state_next = SCA_CAL;
            cnt_next = 7'h01;
        end else if (!convClkRun) begin
            state_next = SCA_IDLE;
            cnt_next = 7'h00;
        end else if (convDone || calDone) begin
            state_next = SCA_IDLE;
            cnt_next = 7'h00;
        end else if (state_reg != SCA_IDLE) begin
            cnt_next = cnt_reg + 7'h01;
        end
    end

    // completion interrupt: completion set wins over host clear
    always_comb begin
        intN_next = intN_reg;
        if (rdFall && !readDone_reg) begin
            intN_next = 1'b1;
        end
        if (wrFall) begin
            intN_next = 1'b1;
        end
        if (convDone && convClkRun && !startConv) begin
            intN_next = 1'b0;
        end
    end

    // ratiometric magnitude with saturation
    wire [12:0] magClip = (inMagnitude >= refMagnitude) ? RES_POS_FS :
        ((refMagnitude == 13'h0000) ? 13'h0000 :
        13'((26'(inMagnitude) * 26'h0FFF) / 26'(refMagnitude)));
    wire [12:0] magNeg = (magClip == RES_POS_FS) ? RES_NEG_FS :
        13'(~magClip + 13'h0001);
    wire [12:0] resNew = inNegative ? magNeg : magClip;
    wire sampling = (state_reg == SCA_CONV) && (cnt_reg >= SAMP_FIRST) &&
        (cnt_reg <= SAMP_LAST);

    // state registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= SCA_IDLE;
            cnt_reg <= 7'h00;
            intN_reg <= 1'b1;
            rdLow_reg <= 1'b0;
            wrLow_reg <= 1'b0;
            cmdLatch_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            intN_reg <= intN_next;
            rdLow_reg <= rdLow;
            wrLow_reg <= wrLow;
            if (wrLow) begin
                cmdLatch_reg <= dataIn;
            end
        end
    end

    // calibration validity and first-read tracking
    always_ff @(posedge clk) begin
        if (rst) begin
            calValid_reg <= 1'b0;
            readDone_reg <= 1'b0;
        end else begin
            if (!convClkRun || startCal) begin
                calValid_reg <= 1'b0;
            end else if (calDone) begin
                calValid_reg <= 1'b1;
            end
            if (convDone) begin
                readDone_reg <= 1'b0;
            end else if (rdFall) begin
                readDone_reg <= 1'b1;
            end
        end
    end

    // result capture during sampling, ready wait states, read data
    always_ff @(posedge clk) begin
        if (rst) begin
            res_reg <= RES_RESET;
            wait_reg <= 2'h0;
            dataOut <= 16'h0000;
        end else begin
            if (sampling && cnt_reg == SAMP_LAST) begin
                res_reg <= resNew;
            end
            if (rdFall || wrFall) begin
                wait_reg <= WAIT_CYCLES;
            end else if (wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end
            dataOut <= {{3{res_reg[12]}}, res_reg};
        end
    end

    // outputs
    assign dataOe = rdLow;
    assign readyOut = ~((rdFall | wrFall) | (wait_reg != 2'h0));
    assign intN = intN_reg;
    assign samplingOut = sampling;
    assign calValidOut = calValid_reg;
    assign busyOut = (state_reg != SCA_IDLE);

    // assertions
    conv_length_a: assert property (@(posedge clk) disable iff (rst)
        (startConv && !rst) |=> (cnt_reg == 7'h01 && state_reg == SCA_CONV))
        else $error("conversion did not restart at cycle one");
    conv_done_a: assert property (@(posedge clk) disable iff (rst)
        (convDone && convClkRun && !startConv) |=> !intN)
        else $error("interrupt not asserted after cycle 27");
    rd_clear_a: assert property (@(posedge clk) disable iff (rst)
        (rdFall && !readDone_reg && !convDone) |=> intN)
        else $error("read did not clear interrupt");
    wr_clear_a: assert property (@(posedge clk) disable iff (rst)
        (wrFall && !convDone) |=> intN)
        else $error("write did not clear interrupt");
    ready_wait_a: assert property (@(posedge clk) disable iff (rst)
        (rdFall && !wrFall) |-> !readyOut ##1 !readyOut ##1 readyOut)
        else $error("ready wait state wrong");
    cal_len_a: assert property (@(posedge clk) disable iff (rst)
        (calDone && convClkRun && !startConv && !startCal) |=>
        (!busyOut && calValidOut))
        else $error("calibration did not end after its last clock");
    clk_stop_a: assert property (@(posedge clk) disable iff (rst)
        !convClkRun |=> !calValidOut)
        else $error("calibration kept after clock stop");
    bad_cmd_a: assert property (@(posedge clk) disable iff (rst)
        (wrRise && cmd == SCA_CMD_NONE && state_reg == SCA_CONV &&
        convClkRun && !convDone) |=> cnt_reg == $past(cnt_reg) + 7'h01)
        else $error("unknown command disturbed sequence");
    samp_win_a: assert property (@(posedge clk) disable iff (rst)
        samplingOut |-> (cnt_reg >= 7'h03 && cnt_reg <= 7'h0A))
        else $error("sampling outside window");
    read_data_a: assert property (@(posedge clk) disable iff (rst)
        dataOe |-> dataOut[15:12] == {4{dataOut[12]}})
        else $error("result sign not extended");
endmodule

//--- include/sca_pkg.sv
package sca_pkg;
    // command field on the top six data lines
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 10;
    localparam int RES_W = 13;
    // sequence lengths in converter clocks
    localparam logic [6:0] CAL_CYCLES = 7'h69;
    localparam logic [6:0] CONV_CYCLES = 7'h1B;
    // analog sampling window inside a conversion
    localparam logic [6:0] SAMP_FIRST = 7'h03;
    localparam logic [6:0] SAMP_LAST = 7'h0A;
    // result code limits
    localparam logic [12:0] RES_POS_FS = 13'h0FFF;
    localparam logic [12:0] RES_NEG_FS = 13'h1000;
    localparam logic [12:0] RES_RESET = 13'h0000;
    localparam logic [11:0] MAG_RESET = 12'h000;
    // ready wait states added after the strobe edge cycle of each access
    localparam logic [1:0] WAIT_CYCLES = 2'h1;

    typedef enum logic [1:0] {
        SCA_IDLE = 2'b00,
        SCA_CAL = 2'b01,
        SCA_CONV = 2'b10
    } sca_state_t;

    typedef enum logic [1:0] {
        SCA_CMD_NONE = 2'b00,
        SCA_CMD_CAL = 2'b01,
        SCA_CMD_CONV = 2'b10
    } sca_cmd_t;

    // host strobes grouped
    typedef struct packed {
        logic csN;
        logic rdN;
        logic wrN;
    } sca_strobe_t;
endpackage

//--- hdl/sca_cmd_decode.sv
`timescale 1ns/1ps
module sca_cmd_decode
    import sca_pkg::*;
(
    // command field
    input wire logic [5:0] field,
    // decoded command
    output sca_cmd_t cmd
);
    // bit 5 is D15, bit 0 is D10
    wire isConv = field[5] & ~field[4] & ~field[0];
    wire isCal = ~field[5] & (field[3:0] == 4'h0);
    // patterns are disjoint on D15; anything else starts nothing
    assign cmd = isConv ? SCA_CMD_CONV :
                 isCal ? SCA_CMD_CAL : SCA_CMD_NONE;
endmodule

//--- verification/sca_host_model.sv
`timescale 1ns/1ps
module sca_host_model
    import sca_pkg::*;
(
    // clock and device answers
    input wire logic clk,
    input wire logic readyOut,
    input wire logic [15:0] dataOut,
    // host bus drive
    output sca_strobe_t strobe,
    output logic [15:0] dataIn
);
    initial begin
        strobe = 3'b111;
        dataIn = 16'h0000;
    end
    // one host access, held until ready is seen high at an edge
    task automatic access(input logic isRd, input logic [15:0] d,
                          output logic [15:0] q);
        int n;
        n = 0;
        @(posedge clk);
        strobe <= '{csN: 1'b0, rdN: ~isRd, wrN: isRd};
        dataIn <= d;
        do begin
            @(posedge clk);
            n++;
        end while (readyOut !== 1'b1 || n < 2);
        q = dataOut;
        // rising strobes end the low interval; bus shows no stale word
        strobe <= 3'b111;
        dataIn <= ~d;
        @(posedge clk);
    endtask
endmodule

//--- verification/sca_host_port_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    tests_run++; \
    if ((got) !== (ex)) begin \
        fail_count++; \
        $display("[ERR] %s exp %h got %h", nm, ex, got); \
    end
module sca_host_port_test;
    import sca_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic convClkRun = 1'b1;
    logic strapInput = 1'b1;
    logic inNegative = 1'b0;
    logic [12:0] inMagnitude = 13'h0000;
    logic [12:0] refMagnitude = 13'h1000;
    sca_strobe_t strobe;
    logic [15:0] dataIn, dataOut, q;
    logic dataOe, readyOut, intN, samplingOut, calValidOut, busyOut;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int nBusy, nSamp;
    int nWait = 0;
    int nOe = 0;
    always #20 clk = ~clk;
    sca_host_port dut_u (.clk(clk), .rst(rst), .strobe(strobe),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .readyOut(readyOut), .intN(intN), .convClkRun(convClkRun),
        .strapInput(strapInput), .inNegative(inNegative),
        .inMagnitude(inMagnitude), .refMagnitude(refMagnitude),
        .samplingOut(samplingOut), .calValidOut(calValidOut),
        .busyOut(busyOut));
    sca_host_model host_u (.clk(clk), .readyOut(readyOut),
        .dataOut(dataOut), .strobe(strobe), .dataIn(dataIn));
    task automatic results();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // count busy and sampling cycles until the sequence ends
    task automatic wait_idle();
        nBusy = 0;
        nSamp = 0;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            if (samplingOut === 1'b1) nSamp++;
            if (busyOut === 1'b1) nBusy++;
            else if (nBusy > 0) break;
        end
    endtask
    // convert one input and read it back
    task automatic conv(input logic neg, input logic [12:0] mag,
                        input logic [15:0] cmd, input logic [15:0] ex);
        @(posedge clk);
        inNegative <= neg;
        inMagnitude <= mag;
        host_u.access(1'b0, cmd, q);
        wait_idle();
        `CHK("conv cycles", 27, nBusy)
        `CHK("samp cycles", 8, nSamp)
        `CHK("int low", 1'b0, intN)
        nWait = 0;
        nOe = 0;
        host_u.access(1'b1, 16'h0000, q);
        `CHK("wait states", 2, nWait)
        `CHK("oe cycles", 3, nOe)
        `CHK("result", ex, q)
        `CHK("int cleared", 1'b1, intN)
    endtask
    // count wait states and read-enable cycles seen at each edge
    always @(posedge clk) begin
        if (readyOut === 1'b0) nWait++;
        if (dataOe === 1'b1) nOe++;
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("reset int", 1'b1, intN)
        `CHK("reset cal", 1'b0, calValidOut)
        host_u.access(1'b0, 16'h4000, q);
        wait_idle();
        `CHK("cal cycles", 105, nBusy)
        `CHK("cal valid", 1'b1, calValidOut)
        conv(1'b0, 13'h1000, 16'hB800, 16'h0FFF);
        conv(1'b1, 13'h1000, 16'h8000, 16'hF000);
        conv(1'b0, 13'h0000, 16'h8000, 16'h0000);
        `CHK("cal kept", 1'b1, calValidOut)
        host_u.access(1'b0, 16'h8000, q);
        repeat (5) @(posedge clk);
        host_u.access(1'b0, 16'h8000, q);
        wait_idle();
        `CHK("restart", 27, nBusy)
        `CHK("int set", 1'b0, intN)
        host_u.access(1'b0, 16'hFC00, q);
        wait_idle();
        `CHK("unknown cmd", 0, nBusy)
        `CHK("wr clears int", 1'b1, intN)
        host_u.access(1'b0, 16'h8000, q);
        host_u.access(1'b0, 16'hFC00, q);
        wait_idle();
        `CHK("unknown keeps", 22, nBusy)
        @(posedge clk);
        convClkRun <= 1'b0;
        @(posedge clk);
        convClkRun <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("cal lost", 1'b0, calValidOut)
        strapInput <= 1'b0;
        host_u.access(1'b0, 16'h8000, q);
        wait_idle();
        `CHK("strap low", 0, nBusy)
        results();
    end
endmodule
